// *** ssr_sticky_status.sv ***
/*
 * Sticky status register bank for two processing elements, reached
 * over an AXI4-Lite slave port.
 * Assumes live flags, event pulses and stack push/pop strobes come from
 * logic on the same clock, CLK, with synchronous active-high RST.
 */
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
// Function
// - Separate register per element; x also shows sequencer stacks, y arithmetic only.
// - A sticky bit stays one after its cause goes away.
// - Latched invalid bit survives a later valid operation until software clears.
// - Bit 0 set whenever the live ALU zero/underflow flag is set.
// - ALU overflow goes to bit 1 for float, bit 2 for fixed.
// - Multiplier overflow goes to bit 6 for fixed, bit 7 for float.
// - Multiplier underflow sets bit 8, multiplier invalid sets bit 9.
// - Bits 0 to 9 stay set until a software write clears them.
// - x bit 17 set on circular overflow of generator one index seven.
// - x bit 18 set on circular overflow of generator two index fifteen.
// - x bit 19 set when the core touches peripheral I/O register space.
// - x bit 20 set on forced long-word access to an odd address.
// - Read-only bit 21 shows PC stack full, not sticky, cleared by pop.
// - Read-only bit 22 shows PC stack empty, one after reset, cleared by push.
// - Read-only bit 23 shows status stack overflow, sticky.
// - Read-only bit 24 shows status stack empty, one after reset.
// - Read-only bit 25 shows loop stacks overflow, sticky.
// - Read-only bit 26 shows loop stacks empty, one after reset.
`timescale 1ns/1ns
`default_nettype none

module ssr_sticky_status #(
	parameter int AXI_ADDR_W     = 4,
	parameter int PC_STACK_DEPTH = ssr_pkg::SSR_PC_DEPTH_DEF,
	parameter int SS_STACK_DEPTH = ssr_pkg::SSR_SS_DEPTH_DEF,
	parameter int LS_STACK_DEPTH = ssr_pkg::SSR_LS_DEPTH_DEF
) (
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                  S_AXI_AWVALID,
	output logic                       S_AXI_AWREADY,
	input  wire logic [31:0]           S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	input  wire logic                  S_AXI_WVALID,
	output logic                       S_AXI_WREADY,
	output logic [1:0]                 S_AXI_BRESP,
	output logic                       S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	input  wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                  S_AXI_ARVALID,
	output logic                       S_AXI_ARREADY,
	output logic [31:0]                S_AXI_RDATA,
	output logic [1:0]                 S_AXI_RRESP,
	output logic                       S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY,
	input  wire logic [1:0]            ALU_ZERO_LIVE,
	input  wire logic [1:0]            ALU_OVERFLOW_LIVE,
	input  wire logic [1:0]            ALU_FLOAT_OP,
	input  wire logic [1:0]            ALU_INVALID_LIVE,
	input  wire logic [1:0]            MULT_OVERFLOW_LIVE,
	input  wire logic [1:0]            MULT_FLOAT_OP,
	input  wire logic [1:0]            MULT_UNDERFLOW_LIVE,
	input  wire logic [1:0]            MULT_INVALID_LIVE,
	input  wire logic                  CIRCBUF_GEN1_OVERFLOW,
	input  wire logic                  CIRCBUF_GEN2_OVERFLOW,
	input  wire logic                  PERIPHERAL_IO_SPACE_ACCESS,
	input  wire logic                  FORCED_LONG_WORD_ACCESS,
	input  wire logic                  LONG_ADDR_ODD,
	input  wire logic                  PC_PUSH,
	input  wire logic                  PC_POP,
	input  wire logic                  STATUS_PUSH,
	input  wire logic                  STATUS_POP,
	input  wire logic                  LOOP_PUSH,
	input  wire logic                  LOOP_POP
);
	import ssr_pkg::*;
	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (AXI_ADDR_W < 3 || AXI_ADDR_W > 32)
		$error("AXI_ADDR_W must lie in 3..32");
	if (PC_STACK_DEPTH < 1 || PC_STACK_DEPTH > 255)
		$error("PC_STACK_DEPTH must lie in 1..255");
	if (SS_STACK_DEPTH < 1 || SS_STACK_DEPTH > 255)
		$error("SS_STACK_DEPTH must lie in 1..255");
	if (LS_STACK_DEPTH < 1 || LS_STACK_DEPTH > 255)
		$error("LS_STACK_DEPTH must lie in 1..255");
	localparam ssr_cnt_t pc_top = SSR_STK_CNT_W'(PC_STACK_DEPTH);
	localparam ssr_cnt_t ss_top = SSR_STK_CNT_W'(SS_STACK_DEPTH);
	localparam ssr_cnt_t ls_top = SSR_STK_CNT_W'(LS_STACK_DEPTH);
	// ************************************************************
	// Functions
	// ************************************************************
	// Word-aligned decode; low two address bits ignored
	function automatic logic sel_hit(input logic [AXI_ADDR_W-1:0] a,
		input logic [31:0] off);
		sel_hit = (a[AXI_ADDR_W-1:2] == off[AXI_ADDR_W-1:2]);
	endfunction
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// ************************************************************
	// Declarations
	// ************************************************************
	logic                  awready_reg;
	logic                  wready_reg;
	logic                  aw_held_reg;
	logic                  w_held_reg;
	logic [AXI_ADDR_W-1:0] awaddr_reg;
	logic [31:0]           wdata_reg;
	logic [3:0]            wstrb_reg;
	logic                  bvalid_reg;
	logic [1:0]            bresp_reg;
	logic                  arready_reg;
	logic                  rvalid_reg;
	logic [31:0]           rdata_reg;
	logic [1:0]            rresp_reg;
	logic                  aw_take;
	logic                  w_take;
	logic                  ar_take;
	logic                  do_write;
	logic                  aw_held_next;
	logic                  w_held_next;
	logic                  bvalid_next;
	logic                  rvalid_next;
	logic                  wr_x;
	logic                  wr_y;
	logic [31:0]           clr_word;
	ssr_arith_t            arith_reg [2];
	ssr_arith_t            arith_clr [2];
	ssr_arith_t            arith_hit [2];
	logic [SSR_SEQ_W-1:0]  seq_reg;
	logic [SSR_SEQ_W-1:0]  seq_hit;
	ssr_cnt_t              pc_depth_reg;
	ssr_cnt_t              ss_depth_reg;
	ssr_cnt_t              ls_depth_reg;
	logic                  ss_ovf_reg;
	logic                  ls_ovf_reg;
	logic [31:0]           read_x;
	logic [31:0]           read_y;
	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************
	assign aw_take  = S_AXI_AWVALID & awready_reg;
	assign w_take   = S_AXI_WVALID & wready_reg;
	assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next  = w_held_reg;
		bvalid_next  = bvalid_reg;
		if (aw_take)
			aw_held_next = 1'b1;
		if (w_take)
			w_held_next = 1'b1;
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
		end else if (bvalid_reg && S_AXI_BREADY) begin
			bvalid_next = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bresp_reg   <= SSR_RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			bvalid_reg  <= bvalid_next;
			awready_reg <= ~aw_held_next & ~bvalid_next;
			wready_reg  <= ~w_held_next & ~bvalid_next;
			if (do_write)
				bresp_reg <= (wr_x | wr_y) ? SSR_RESP_OKAY : SSR_RESP_SLV;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			awaddr_reg <= '0;
			wdata_reg  <= SSR_WORD_ZERO;
			wstrb_reg  <= 4'h0;
		end else begin
			if (aw_take)
				awaddr_reg <= S_AXI_AWADDR;
			if (w_take) begin
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
			end
		end
	end

	assign wr_x     = do_write & sel_hit(awaddr_reg, SSR_OFF_X);
	assign wr_y     = do_write & sel_hit(awaddr_reg, SSR_OFF_Y);
	// Writing one clears; zeros and disabled lanes leave bits alone
	assign clr_word = wdata_reg & lane_mask(wstrb_reg);
	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************
	assign ar_take     = S_AXI_ARVALID & arready_reg;
	assign rvalid_next = ar_take ? 1'b1 :
		((rvalid_reg & S_AXI_RREADY) ? 1'b0 : rvalid_reg);

	always_ff @(posedge CLK) begin
		if (RST) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= SSR_WORD_ZERO;
			rresp_reg   <= SSR_RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
			if (ar_take) begin
				if (sel_hit(S_AXI_ARADDR, SSR_OFF_X)) begin
					rdata_reg <= read_x;
					rresp_reg <= SSR_RESP_OKAY;
				end else if (sel_hit(S_AXI_ARADDR, SSR_OFF_Y)) begin
					rdata_reg <= read_y;
					rresp_reg <= SSR_RESP_OKAY;
				end else begin
					rdata_reg <= SSR_WORD_ZERO;
					rresp_reg <= SSR_RESP_SLV;
				end
			end
		end
	end

	// ************************************************************
	// Arithmetic sticky bits, one set per element
	// ************************************************************
	always_comb begin
		for (int e = 0; e < 2; e++) begin
			arith_hit[e] = arith_set(ALU_ZERO_LIVE[e],
				ALU_OVERFLOW_LIVE[e], ALU_FLOAT_OP[e],
				ALU_INVALID_LIVE[e], MULT_OVERFLOW_LIVE[e],
				MULT_FLOAT_OP[e], MULT_UNDERFLOW_LIVE[e],
				MULT_INVALID_LIVE[e]);
		end
		arith_clr[0] = wr_x ? clr_word[SSR_ARITH_W-1:0] : SSR_ARITH_RST;
		arith_clr[1] = wr_y ? clr_word[SSR_ARITH_W-1:0] : SSR_ARITH_RST;
	end
	// Set beats clear so an event in the clearing cycle is kept
	always_ff @(posedge CLK) begin
		if (RST) begin
			arith_reg[0] <= SSR_ARITH_RST;
			arith_reg[1] <= SSR_ARITH_RST;
		end else begin
			for (int e = 0; e < 2; e++)
				arith_reg[e] <= (arith_reg[e] & ~arith_clr[e])
					| arith_hit[e];
		end
	end

	// ************************************************************
	// Sequencer and address sticky bits, x element only
	// ************************************************************
	assign seq_hit = {FORCED_LONG_WORD_ACCESS & LONG_ADDR_ODD,
		PERIPHERAL_IO_SPACE_ACCESS,
		CIRCBUF_GEN2_OVERFLOW,
		CIRCBUF_GEN1_OVERFLOW};

	always_ff @(posedge CLK) begin
		if (RST)
			seq_reg <= SSR_SEQ_RST;
		else if (wr_x)
			seq_reg <= (seq_reg & ~clr_word[SSR_BIT_LONG:SSR_BIT_CB1])
				| seq_hit;
		else
			seq_reg <= seq_reg | seq_hit;
	end

	// ************************************************************
	// Stack state tracking
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			pc_depth_reg <= SSR_CNT_RST;
			ss_depth_reg <= SSR_CNT_RST;
			ls_depth_reg <= SSR_CNT_RST;
		end else begin
			pc_depth_reg <= stk_next(pc_depth_reg, PC_PUSH, PC_POP,
				pc_top);
			ss_depth_reg <= stk_next(ss_depth_reg, STATUS_PUSH,
				STATUS_POP, ss_top);
			ls_depth_reg <= stk_next(ls_depth_reg, LOOP_PUSH, LOOP_POP,
				ls_top);
		end
	end

	// Overflow indications leave only through reset; software cannot clear
	always_ff @(posedge CLK) begin
		if (RST) begin
			ss_ovf_reg <= 1'b0;
			ls_ovf_reg <= 1'b0;
		end else begin
			if (STATUS_PUSH && !STATUS_POP && ss_depth_reg == ss_top)
				ss_ovf_reg <= 1'b1;
			if (LOOP_PUSH && !LOOP_POP && ls_depth_reg == ls_top)
				ls_ovf_reg <= 1'b1;
		end
	end

	// ************************************************************
	// Read views
	// ************************************************************
	always_comb begin
		read_x = SSR_WORD_ZERO;
		read_x[SSR_ARITH_W-1:0] = arith_reg[0];
		read_x[SSR_BIT_LONG:SSR_BIT_CB1] = seq_reg;
		read_x[SSR_BIT_PC_FULL]  = (pc_depth_reg == pc_top);
		read_x[SSR_BIT_PC_EMPTY] = (pc_depth_reg == SSR_CNT_RST);
		read_x[SSR_BIT_SS_OVF]   = ss_ovf_reg;
		read_x[SSR_BIT_SS_EMPTY] = (ss_depth_reg == SSR_CNT_RST);
		read_x[SSR_BIT_LS_OVF]   = ls_ovf_reg;
		read_x[SSR_BIT_LS_EMPTY] = (ls_depth_reg == SSR_CNT_RST);
		read_y = SSR_WORD_ZERO;
		read_y[SSR_ARITH_W-1:0] = arith_reg[1];
	end
	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY  = wready_reg;
	assign S_AXI_BVALID  = bvalid_reg;
	assign S_AXI_BRESP   = bresp_reg;
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID  = rvalid_reg;
	assign S_AXI_RDATA   = rdata_reg;
	assign S_AXI_RRESP   = rresp_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	chk_alu_under_set: assert property (
		ALU_ZERO_LIVE[0] |=> read_x[SSR_BIT_ALU_UNDER])
		else $error("alu underflow sticky not set");
	chk_sticky_hold: assert property (
		arith_reg[1][SSR_BIT_MUL_INV] && !arith_clr[1][SSR_BIT_MUL_INV]
		|=> arith_reg[1][SSR_BIT_MUL_INV])
		else $error("sticky bit dropped by itself");
	chk_invalid_keep: assert property (
		$fell(ALU_INVALID_LIVE[0]) && arith_reg[0][SSR_BIT_ALU_INV]
		&& !wr_x ##1 !wr_x |-> arith_reg[0][SSR_BIT_ALU_INV])
		else $error("invalid sticky lost after valid op");
	chk_alu_ovf_split: assert property (
		ALU_OVERFLOW_LIVE[1] && !ALU_FLOAT_OP[1] && !arith_reg[1][1]
		|=> arith_reg[1][SSR_BIT_ALU_XOVF] && !arith_reg[1][SSR_BIT_ALU_FOVF])
		else $error("fixed alu overflow in wrong bit");
	chk_mul_ovf_split: assert property (
		MULT_OVERFLOW_LIVE[0] && MULT_FLOAT_OP[0]
		|=> arith_reg[0][SSR_BIT_MUL_FOVF])
		else $error("float mult overflow not in bit 7");
	chk_mul_under_inv: assert property (
		MULT_UNDERFLOW_LIVE[1] && MULT_INVALID_LIVE[1]
		|=> read_y[SSR_BIT_MUL_UNDER] && read_y[SSR_BIT_MUL_INV])
		else $error("mult underflow or invalid not latched");
	chk_clear_write: assert property (
		wr_x && clr_word[SSR_BIT_ALU_UNDER] && !ALU_ZERO_LIVE[0]
		|=> !read_x[SSR_BIT_ALU_UNDER])
		else $error("write of one did not clear bit 0");
	chk_circbuf_set: assert property (
		CIRCBUF_GEN1_OVERFLOW ##1 !wr_x [*2] |-> read_x[SSR_BIT_CB1])
		else $error("circular overflow sticky not held");
	chk_long_odd: assert property (
		FORCED_LONG_WORD_ACCESS && !LONG_ADDR_ODD && !read_x[SSR_BIT_LONG]
		|=> !read_x[SSR_BIT_LONG])
		else $error("even long access flagged");
	chk_pc_push_empty: assert property (
		PC_PUSH && !PC_POP |=> !read_x[SSR_BIT_PC_EMPTY])
		else $error("pc empty not cleared by push");
	chk_pc_pop_full: assert property (
		read_x[SSR_BIT_PC_FULL] && PC_POP && !PC_PUSH
		|=> !read_x[SSR_BIT_PC_FULL])
		else $error("pc full not cleared by pop");
	chk_ss_ovf_sticky: assert property (
		ss_ovf_reg |=> ss_ovf_reg)
		else $error("status overflow dropped");
	chk_y_upper_zero: assert property (
		read_y[31:SSR_ARITH_W] == 22'h000000
		&& read_y[4:3] == 2'h0 && read_x[16:10] == 7'h00)
		else $error("reserved bits not zero");
	// Data is loaded at the taking edge, so only the answer flags are checked
	chk_read_answer: assert property (
		ar_take |=> rvalid_reg && !arready_reg)
		else $error("read answer missing");
	cov_write_clear: cover property (wr_x && clr_word[SSR_BIT_ALU_INV]);
	cov_set_on_clear: cover property (wr_y && arith_hit[1] != SSR_ARITH_RST);
	cov_ss_overflow: cover property ($rose(ss_ovf_reg));
	cov_read_y: cover property (ar_take && sel_hit(S_AXI_ARADDR, SSR_OFF_Y));
endmodule

`default_nettype wire

// *** ssr_pkg.sv ***
/*
 * Constants of the sticky status register bank: offsets, bit positions,
 * reset values, bus answer codes and stack depth defaults.
 * Assumes a 32-bit AXI4-Lite register bus and one core clock.
 */
`default_nettype none

package ssr_pkg;

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [31:0] SSR_OFF_X = 32'h0000_0000;
	localparam logic [31:0] SSR_OFF_Y = 32'h0000_0004;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int SSR_ARITH_W       = 10;
	localparam int SSR_BIT_ALU_UNDER = 0;
	localparam int SSR_BIT_ALU_FOVF  = 1;
	localparam int SSR_BIT_ALU_XOVF  = 2;
	localparam int SSR_BIT_ALU_INV   = 5;
	localparam int SSR_BIT_MUL_XOVF  = 6;
	localparam int SSR_BIT_MUL_FOVF  = 7;
	localparam int SSR_BIT_MUL_UNDER = 8;
	localparam int SSR_BIT_MUL_INV   = 9;
	localparam int SSR_BIT_CB1       = 17;
	localparam int SSR_BIT_CB2       = 18;
	localparam int SSR_BIT_IOP       = 19;
	localparam int SSR_BIT_LONG      = 20;
	localparam int SSR_BIT_PC_FULL   = 21;
	localparam int SSR_BIT_PC_EMPTY  = 22;
	localparam int SSR_BIT_SS_OVF    = 23;
	localparam int SSR_BIT_SS_EMPTY  = 24;
	localparam int SSR_BIT_LS_OVF    = 25;
	localparam int SSR_BIT_LS_EMPTY  = 26;
	localparam int SSR_SEQ_W         = 4;

	// ************************************************************
	// Reset values and codes
	// ************************************************************
	localparam logic [9:0]  SSR_ARITH_RST = 10'h000;
	localparam logic [3:0]  SSR_SEQ_RST   = 4'h0;
	localparam logic [31:0] SSR_WORD_ZERO = 32'h0000_0000;
	localparam logic [1:0]  SSR_RESP_OKAY = 2'h0;
	localparam logic [1:0]  SSR_RESP_SLV  = 2'h2;

	// ************************************************************
	// Stack tracking
	// ************************************************************
	localparam int SSR_STK_CNT_W     = 8;
	localparam int SSR_PC_DEPTH_DEF  = 8;
	localparam int SSR_SS_DEPTH_DEF  = 8;
	localparam int SSR_LS_DEPTH_DEF  = 8;
	localparam logic [7:0] SSR_CNT_RST = 8'h00;

	typedef logic [SSR_ARITH_W-1:0] ssr_arith_t;
	typedef logic [SSR_STK_CNT_W-1:0] ssr_cnt_t;

	// ************************************************************
	// Shared set steering and stack depth arithmetic
	// ************************************************************
	function automatic ssr_arith_t arith_set(input logic zero,
		input logic aovf, input logic aflt, input logic ainv,
		input logic movf, input logic mflt, input logic mund,
		input logic minv);
		ssr_arith_t s;
		s = SSR_ARITH_RST;
		s[SSR_BIT_ALU_UNDER] = zero;
		s[SSR_BIT_ALU_FOVF]  = aovf & aflt;
		s[SSR_BIT_ALU_XOVF]  = aovf & ~aflt;
		s[SSR_BIT_ALU_INV]   = ainv;
		s[SSR_BIT_MUL_XOVF]  = movf & ~mflt;
		s[SSR_BIT_MUL_FOVF]  = movf & mflt;
		s[SSR_BIT_MUL_UNDER] = mund;
		s[SSR_BIT_MUL_INV]   = minv;
		arith_set = s;
	endfunction

	// Saturating depth; push at full and pop at empty leave depth unchanged
	function automatic ssr_cnt_t stk_next(input ssr_cnt_t d,
		input logic push, input logic pop, input ssr_cnt_t top);
		stk_next = d;
		if (push && !pop && d != top)
			stk_next = d + SSR_STK_CNT_W'(1);
		else if (pop && !push && d != SSR_CNT_RST)
			stk_next = d - SSR_STK_CNT_W'(1);
	endfunction

endpackage

`default_nettype wire

// *** ssr_core_model.sv ***
/*
 * Far-side model: arithmetic units, address generators and sequencer
 * stacks, all packed into one operation vector.
 * Assumes it shares CLK with the register bank and that the caller
 * enters issue just after a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none

module ssr_core_model (
	input  wire logic        CLK,
	output logic [26:0]      OPS
);
	// ************************************************************
	// One operation per call
	// ************************************************************
	initial OPS = 27'h000_0000;

	// Live flags last one cycle: the next, valid operation drops them
	task automatic issue(input logic [26:0] v);
		@(posedge CLK);
		OPS <= v;
		@(posedge CLK);
		OPS <= 27'h000_0000;
	endtask
endmodule

`default_nettype wire

// *** sticky_status_registers_tb.sv ***
/*
 * Self-checking bench for the sticky status register bank.
 * Assumes ssr_pkg, ssr_sticky_status and ssr_core_model compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module sticky_status_registers_tb_top;
	import ssr_pkg::*;
	// Small depth so full and overflow are reached quickly
	localparam int D = 2;
	logic        clk, rst, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, st_ovf, lp_ovf;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, seed, sx, sy;
	logic [1:0]  bresp, rresp;
	logic [26:0] ops, v;
	int          fail_count, total_checks, pc, ss, ls;
	logic [26:0] combo [5] = '{27'h6, 27'h30, 27'h600, 27'h3000, 27'h18_0000};

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	ssr_core_model i_ssr_core_model (.CLK(clk), .OPS(ops));

	ssr_sticky_status #(.PC_STACK_DEPTH(D), .SS_STACK_DEPTH(D),
		.LS_STACK_DEPTH(D)) i_ssr_sticky_status (
		.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .ALU_ZERO_LIVE({ops[8], ops[0]}),
		.ALU_OVERFLOW_LIVE({ops[9], ops[1]}), .ALU_FLOAT_OP({ops[10], ops[2]}),
		.ALU_INVALID_LIVE({ops[11], ops[3]}),
		.MULT_OVERFLOW_LIVE({ops[12], ops[4]}),
		.MULT_FLOAT_OP({ops[13], ops[5]}),
		.MULT_UNDERFLOW_LIVE({ops[14], ops[6]}),
		.MULT_INVALID_LIVE({ops[15], ops[7]}),
		.CIRCBUF_GEN1_OVERFLOW(ops[16]), .CIRCBUF_GEN2_OVERFLOW(ops[17]),
		.PERIPHERAL_IO_SPACE_ACCESS(ops[18]),
		.FORCED_LONG_WORD_ACCESS(ops[19]), .LONG_ADDR_ODD(ops[20]),
		.PC_PUSH(ops[21]), .PC_POP(ops[22]), .STATUS_PUSH(ops[23]),
		.STATUS_POP(ops[24]), .LOOP_PUSH(ops[25]), .LOOP_POP(ops[26]));

	// ************************************************************
	// Expectation model
	// ************************************************************
	function automatic logic [31:0] xs(input logic [31:0] x);
		xs = x ^ (x << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction

	function automatic logic [31:0] am(input logic [7:0] a);
		am = 32'h0000_0000;
		am[0] = a[0];
		am[1] = a[1] & a[2];
		am[2] = a[1] & ~a[2];
		am[5] = a[3];
		am[6] = a[4] & ~a[5];
		am[7] = a[4] & a[5];
		am[8] = a[6];
		am[9] = a[7];
	endfunction

	function automatic int step(input int d, input logic pu, input logic po);
		step = d;
		if (pu && !po && d < D) step = d + 1;
		if (po && !pu && d > 0) step = d - 1;
	endfunction

	function automatic logic [31:0] ex();
		ex = sx;
		ex[21] = (pc == D);
		ex[22] = (pc == 0);
		ex[23] = st_ovf;
		ex[24] = (ss == 0);
		ex[25] = lp_ovf;
		ex[26] = (ls == 0);
	endfunction

	task automatic act(input logic [26:0] o);
		i_ssr_core_model.issue(o);
		sx = sx | am(o[7:0]) | {11'h000, o[19] & o[20], o[18:16], 17'h0_0000};
		sy = sy | am(o[15:8]);
		st_ovf = st_ovf | (o[23] & ~o[24] & (ss == D));
		lp_ovf = lp_ovf | (o[25] & ~o[26] & (ls == D));
		pc = step(pc, o[21], o[22]);
		ss = step(ss, o[23], o[24]);
		ls = step(ls, o[25], o[26]);
	endtask

	// ************************************************************
	// Checks and bus cycles
	// ************************************************************
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= 40) begin
			fail_count++;
			$display("wrong value bus wait expected answer seen none");
			results();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		logic ta, tw;
		logic [1:0] er;
		logic [31:0] m;
		n = 0;
		ta = 1'b0;
		tw = 1'b0;
		er = (a[3:2] > 2'h1) ? SSR_RESP_SLV : SSR_RESP_OKAY;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready && !ta) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !tw) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!bvalid && n < 40);
		bready <= 1'b0;
		tmo(n);
		chk("bresp", {30'h0000_0000, er}, {30'h0000_0000, bresp});
		m = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		if (a[3:2] == 2'h0) sx = sx & ~(m & 32'h001E_03E7);
		if (a[3:2] == 2'h1) sy = sy & ~(m & 32'h0000_03E7);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		int n;
		logic ta;
		logic [1:0] er;
		n = 0;
		ta = 1'b0;
		er = (a[3:2] > 2'h1) ? SSR_RESP_SLV : SSR_RESP_OKAY;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready && !ta) begin
				ta = 1'b1;
				arvalid <= 1'b0;
			end
		end while (!rvalid && n < 40);
		rready <= 1'b0;
		tmo(n);
		chk("rresp", {30'h0000_0000, er}, {30'h0000_0000, rresp});
		chk("rdata", e, rdata);
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		sx = 32'h0000_0000;
		sy = 32'h0000_0000;
		pc = 0;
		ss = 0;
		ls = 0;
		st_ovf = 1'b0;
		lp_ovf = 1'b0;
		@(posedge clk);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wstrb} = 12'h000;
		wdata = 32'h0000_0000;
		seed = 32'h0000_0AEE;
		fail_count = 0;
		total_checks = 0;
		do_reset();
		rd(4'h0, ex());
		rd(4'h8, 32'h0000_0000);
		wr(4'hC, 32'hFFFF_FFFF, 4'hF);
		wr(4'h0, 32'hFFFF_FFFF, 4'hF);
		rd(4'h0, ex());
		// Each cause alone on bits 0 to 20, including qualifiers that must not set anything, then five cause and qualifier pairs
		for (int i = 0; i < 26; i++) begin
			v = (i < 21) ? (27'h1 << i) : combo[i - 21];
			act(v);
			rd(4'h0, ex());
			rd(4'h4, sy);
			wr(4'h0, 32'hFFFF_FFFF, 4'hF);
			wr(4'h4, 32'hFFFF_FFFF, 4'hF);
			rd(4'h0, ex());
			rd(4'h4, sy);
		end
		act(27'h000_0008);
		act(27'h000_0000);
		rd(4'h0, ex());
		repeat (3) begin
			act(27'h2A0_0000);
			rd(4'h0, ex());
		end
		wr(4'h0, 32'hFFFF_FFFF, 4'hF);
		repeat (3) begin
			act(27'h540_0000);
			rd(4'h0, ex());
		end
		// Second reset in mid-run, then random traffic and clears
		do_reset();
		rd(4'h0, ex());
		repeat (60) begin
			seed = xs(seed);
			act(seed[26:0]);
			seed = xs(seed);
			wr({seed[5] & seed[6], seed[4], 2'h0}, seed, seed[11:8]);
			rd(4'h0, ex());
			rd(4'h4, sy);
		end
		results();
	end
endmodule

`default_nettype wire
